// ---- include/mies_pkg.sv ----
// mies_pkg: constants, opcodes and types of the instruction execute block.
// assumes: 14-bit instruction words, 8-bit data, 32-bit register bus.
`default_nettype none

package mies_pkg;
	// ----------------------------------------------------------------
	// instruction fields
	// ----------------------------------------------------------------
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int LOWREG_W = 6;

	// upper six opcode bits
	localparam logic [5:0] OPH_SYSTEM = 6'h00;
	localparam logic [5:0] OPH_FILE_MINUS_ACC = 6'h02;
	localparam logic [5:0] OPH_OR_REGISTER = 6'h04;
	localparam logic [5:0] OPH_XOR_REGISTER = 6'h06;
	localparam logic [5:0] OPH_MOVE_OR_TEST = 6'h08;
	localparam logic [5:0] OPH_INCREMENT_FILE = 6'h0A;
	localparam logic [5:0] OPH_ROTATE_RIGHT = 6'h0C;
	localparam logic [5:0] OPH_ROTATE_LEFT = 6'h0D;
	localparam logic [5:0] OPH_NIBBLE_EXCHANGE = 6'h0E;
	localparam logic [5:0] OPH_INCREMENT_SKIP = 6'h0F;
	localparam logic [5:0] OPH_LITERAL_RETURN = 6'h18;
	localparam logic [5:0] OPH_MOVE_LITERAL = 6'h19;
	localparam logic [5:0] OPH_OR_LITERAL = 6'h1A;
	localparam logic [5:0] OPH_LITERAL_MINUS_ACC = 6'h1D;
	localparam logic [5:0] OPH_XOR_LITERAL = 6'h1F;

	// low byte of the system group
	localparam logic [7:0] OPL_NO_OPERATION = 8'h00;
	localparam logic [7:0] OPL_POWER_DOWN = 8'h03;
	localparam logic [7:0] OPL_WDOG_CLEAR = 8'h04;
	localparam logic [7:0] OPL_SUBROUTINE_RETURN = 8'h40;
	localparam logic [7:0] OPL_INTERRUPT_RETURN = 8'h60;
	localparam logic [7:0] OPL_TABLE_READ_LOWER = 8'h50;
	localparam logic [7:0] OPL_TABLE_READ_UPPER = 8'h58;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam logic [5:0] REG_INSTR = 6'h00;
	localparam logic [5:0] REG_ACC = 6'h04;
	localparam logic [5:0] REG_STATUS = 6'h08;
	localparam logic [5:0] REG_PROG_COUNT = 6'h0C;
	localparam logic [5:0] REG_FILE_INDEX = 6'h10;
	localparam logic [5:0] REG_FILE_DATA = 6'h14;
	localparam logic [5:0] REG_STACK = 6'h18;

	// status bit positions
	localparam int ST_CARRY = 0;
	localparam int ST_HALF_ROLLOVER = 1;
	localparam int ST_ZERO = 2;
	localparam int ST_POWERDOWN_FLAG = 3;
	localparam int ST_TIMEOUT_FLAG = 4;
	localparam int ST_GLOBAL_IRQ = 5;
	localparam int ST_SLEEPING = 6;
	localparam int ST_SKIP_PENDING = 7;

	// file addresses of the table pointer parts
	localparam logic [6:0] FADDR_INDIRECT_SELECT = 7'h04;
	localparam logic [6:0] FADDR_TABLE_HIGH = 7'h05;

	// reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic FLAG_RST = 1'b0;
	localparam logic POWER_FLAGS_RST = 1'b1;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC2 = 2'b01,
		ST_ACK = 2'b10
	} mies_state_type;

	typedef enum logic [4:0] {
		OP_NONE = 5'b00000,
		OP_INCREMENT_FILE = 5'b00001,
		OP_INCREMENT_SKIP = 5'b00010,
		OP_OR_LITERAL = 5'b00011,
		OP_OR_REGISTER = 5'b00100,
		OP_MOVE_FILE_TO_ACC = 5'b00101,
		OP_MOVE_LITERAL = 5'b00110,
		OP_MOVE_ACC_TO_FILE = 5'b00111,
		OP_MOVE_ACC_TO_LOW_REG = 5'b01000,
		OP_SUBROUTINE_RETURN = 5'b01001,
		OP_INTERRUPT_RETURN = 5'b01010,
		OP_LITERAL_RETURN = 5'b01011,
		OP_ROTATE_LEFT = 5'b01100,
		OP_ROTATE_RIGHT = 5'b01101,
		OP_POWER_DOWN = 5'b01110,
		OP_LITERAL_MINUS_ACC = 5'b01111,
		OP_FILE_MINUS_ACC = 5'b10000,
		OP_NIBBLE_EXCHANGE = 5'b10001,
		OP_TABLE_READ_UPPER = 5'b10010,
		OP_TABLE_READ_LOWER = 5'b10011,
		OP_ZERO_TEST = 5'b10100,
		OP_XOR_LITERAL = 5'b10101,
		OP_XOR_REGISTER = 5'b10110
	} mies_op_type;
endpackage

`default_nettype wire

// ---- logic/mies_core.sv ----
// mies_core: executes a subset of 14-bit microcontroller instructions.
// assumes: avalon-mm master on sys_clk_i, program rom with combinational
// read on the same clock, synchronous active-low reset.
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// [RL1] increment file into chosen destination, zero flag
// [RL2] increment, skip next when zero, no flags
// [RL3] or literal into accumulator, zero flag
// [RL4] or accumulator with file, destination bit
// [RL5] move file to accumulator, no flags
// [RL6] load literal into accumulator, no flags
// [RL7] store accumulator into 7-bit file address
// [RL8] store accumulator into 6-bit low register
// [RL9] pop stack into program counter, two cycles
// [RL10] pop stack, set global interrupt enable
// [RL11] literal to accumulator and pop return
// [RL12] rotate left through carry
// [RL13] rotate right through carry
// [RL14] power down sets timeout flag, clears power-down flag, stops oscillator
// [RL15] literal minus accumulator, carry means no borrow
// [RL16] file minus accumulator, carry means no borrow
// [RL17] exchange nibbles, no flags
// [RL18] table address high over indirect select; upper read
// [RL19] lower table read into accumulator, two cycles
// [RL20] zero test leaves file unchanged
// [RL21] xor literal into accumulator, zero flag
// [RL22] xor accumulator with file, destination bit
// [RL23] zero flag set only for all-zero result
// [RL24] all-zero opcode only advances program counter
module mies_core #(
	parameter int ROM_AW = 11,
	parameter int STACK_DEPTH = 5,
	parameter int FILE_N = 128
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic [mies_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [ROM_AW-1:0] rom_addr_o,
	output logic rom_rd_o,
	input wire logic [mies_pkg::INSTR_W-1:0] rom_data_i,
	output logic osc_stop_o,
	output logic global_irq_enable_o
);

	localparam int SP_W = $clog2(STACK_DEPTH + 1);

	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	generate
		if (ROM_AW < 9 || ROM_AW > 16) begin : g_bad_rom
			$error("ROM_AW must lie between 9 and 16");
		end
		if (STACK_DEPTH < 1 || STACK_DEPTH > 16) begin : g_bad_stack
			$error("STACK_DEPTH must lie between 1 and 16");
		end
		if (FILE_N != 128) begin : g_bad_file
			$error("FILE_N must be 128 for a 7-bit file address");
		end
	endgenerate

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		mies_pkg::mies_state_type st;
		logic waitreq;
		logic [31:0] rdata;
		logic [7:0] acc;
		logic carry;
		logic half_rollover_bit;
		logic zero;
		logic powerdown_flag;
		logic timeout_flag;
		logic global_irq_enable;
		logic sleeping;
		logic skip;
		logic [ROM_AW-1:0] program_counter;
		logic [FILE_N-1:0][7:0] file;
		logic [STACK_DEPTH-1:0][ROM_AW-1:0] stack;
		logic [SP_W-1:0] depth;
		logic [ROM_AW-1:0] rom_addr;
		logic rom_rd;
		logic tbl_upper;
		logic [6:0] file_index;
		logic [mies_pkg::INSTR_W-1:0] last_instr;
	} mies_regs_type;

	mies_regs_type s_r;
	mies_regs_type s_nxt;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] m;
		m = old;
		if (be[0]) begin
			m[7:0] = wd[7:0];
		end
		if (be[1]) begin
			m[15:8] = wd[15:8];
		end
		return m;
	endfunction

	function automatic mies_pkg::mies_op_type decode(
			input logic [mies_pkg::INSTR_W-1:0] iw);
		mies_pkg::mies_op_type op;
		op = mies_pkg::OP_NONE;
		case (iw[13:8])
			mies_pkg::OPH_INCREMENT_FILE: op = mies_pkg::OP_INCREMENT_FILE;
			mies_pkg::OPH_INCREMENT_SKIP: op = mies_pkg::OP_INCREMENT_SKIP;
			mies_pkg::OPH_OR_LITERAL: op = mies_pkg::OP_OR_LITERAL;
			mies_pkg::OPH_OR_REGISTER: op = mies_pkg::OP_OR_REGISTER;
			mies_pkg::OPH_MOVE_LITERAL: op = mies_pkg::OP_MOVE_LITERAL;
			mies_pkg::OPH_LITERAL_RETURN: op = mies_pkg::OP_LITERAL_RETURN;
			mies_pkg::OPH_ROTATE_LEFT: op = mies_pkg::OP_ROTATE_LEFT;
			mies_pkg::OPH_ROTATE_RIGHT: op = mies_pkg::OP_ROTATE_RIGHT;
			mies_pkg::OPH_LITERAL_MINUS_ACC: op = mies_pkg::OP_LITERAL_MINUS_ACC;
			mies_pkg::OPH_FILE_MINUS_ACC: op = mies_pkg::OP_FILE_MINUS_ACC;
			mies_pkg::OPH_NIBBLE_EXCHANGE: op = mies_pkg::OP_NIBBLE_EXCHANGE;
			mies_pkg::OPH_XOR_LITERAL: op = mies_pkg::OP_XOR_LITERAL;
			mies_pkg::OPH_XOR_REGISTER: op = mies_pkg::OP_XOR_REGISTER;
			mies_pkg::OPH_MOVE_OR_TEST: begin
				op = iw[7] ? mies_pkg::OP_ZERO_TEST
					: mies_pkg::OP_MOVE_FILE_TO_ACC;
			end
			mies_pkg::OPH_SYSTEM: begin
				// exact codes win over the low-register store pattern
				if (iw[7]) begin
					op = mies_pkg::OP_MOVE_ACC_TO_FILE;
				end else if (iw[7:0] == mies_pkg::OPL_POWER_DOWN) begin
					op = mies_pkg::OP_POWER_DOWN;
				end else if (iw[7:0] == mies_pkg::OPL_SUBROUTINE_RETURN) begin
					op = mies_pkg::OP_SUBROUTINE_RETURN;
				end else if (iw[7:0] == mies_pkg::OPL_INTERRUPT_RETURN) begin
					op = mies_pkg::OP_INTERRUPT_RETURN;
				end else if (iw[7:0] == mies_pkg::OPL_TABLE_READ_UPPER) begin
					op = mies_pkg::OP_TABLE_READ_UPPER;
				end else if (iw[7:0] == mies_pkg::OPL_TABLE_READ_LOWER) begin
					op = mies_pkg::OP_TABLE_READ_LOWER;
				end else if (iw[7:6] == 2'b00
						&& iw[7:0] != mies_pkg::OPL_NO_OPERATION
						&& iw[7:0] != mies_pkg::OPL_WDOG_CLEAR) begin
					op = mies_pkg::OP_MOVE_ACC_TO_LOW_REG;
				end
			end
			default: op = mies_pkg::OP_NONE;
		endcase
		return op;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		mies_pkg::mies_op_type op;
		logic [mies_pkg::INSTR_W-1:0] iw;
		logic [6:0] fa;
		logic [7:0] fv;
		logic [7:0] kv;
		logic [7:0] res;
		logic [8:0] diff;
		logic [4:0] hdiff;
		logic dst_file;
		logic wr_res;
		logic [15:0] wv;
		op = mies_pkg::OP_NONE;
		iw = '0;
		fa = '0;
		fv = '0;
		kv = '0;
		res = '0;
		diff = '0;
		hdiff = '0;
		dst_file = 1'b0;
		wr_res = 1'b0;
		wv = '0;
		s_nxt = s_r;
		if (!rst_n_i) begin
			s_nxt = '0;
			s_nxt.st = mies_pkg::ST_IDLE;
			s_nxt.waitreq = 1'b1;
			s_nxt.acc = mies_pkg::ACC_RST;
			s_nxt.carry = mies_pkg::FLAG_RST;
			s_nxt.half_rollover_bit = mies_pkg::FLAG_RST;
			s_nxt.zero = mies_pkg::FLAG_RST;
			s_nxt.powerdown_flag = mies_pkg::POWER_FLAGS_RST;
			s_nxt.timeout_flag = mies_pkg::POWER_FLAGS_RST;
		end else if (clk_en_i) begin
			unique case (s_r.st)
				mies_pkg::ST_IDLE: begin
					if (avs_write_i) begin
						s_nxt.waitreq = 1'b0;
						s_nxt.st = mies_pkg::ST_ACK;
						unique case (avs_address_i)
							mies_pkg::REG_INSTR: begin
								wv = merge16({2'b00, s_r.last_instr},
									avs_writedata_i, avs_byteenable_i);
								iw = wv[13:0];
								s_nxt.last_instr = iw;
								op = decode(iw);
								fa = iw[6:0];
								fv = s_r.file[fa];
								kv = iw[7:0];
								dst_file = iw[7];
								if (s_r.sleeping) begin
									op = mies_pkg::OP_NONE;
								end else if (s_r.skip) begin
									// discarded word runs as a no-operation
									op = mies_pkg::OP_NONE;
									s_nxt.skip = 1'b0;
									s_nxt.program_counter = ROM_AW'(s_r.program_counter + 1'b1); // [RL2]
								end else begin
									s_nxt.program_counter = ROM_AW'(s_r.program_counter + 1'b1); // [RL24]
								end
								unique case (op)
									mies_pkg::OP_INCREMENT_FILE: begin
										res = fv + 8'h01; // [RL1]
										wr_res = 1'b1;
										s_nxt.zero = (res == 8'h00); // [RL23]
									end
									mies_pkg::OP_INCREMENT_SKIP: begin
										res = fv + 8'h01;
										wr_res = 1'b1;
										s_nxt.skip = (res == 8'h00); // [RL2]
									end
									mies_pkg::OP_OR_LITERAL: begin
										s_nxt.acc = s_r.acc | kv; // [RL3]
										s_nxt.zero = ((s_r.acc | kv) == 8'h00); // [RL23]
									end
									mies_pkg::OP_OR_REGISTER: begin
										res = s_r.acc | fv; // [RL4]
										wr_res = 1'b1;
										s_nxt.zero = (res == 8'h00);
									end
									mies_pkg::OP_XOR_LITERAL: begin
										s_nxt.acc = s_r.acc ^ kv; // [RL21]
										s_nxt.zero = ((s_r.acc ^ kv) == 8'h00); // [RL23]
									end
									mies_pkg::OP_XOR_REGISTER: begin
										res = s_r.acc ^ fv; // [RL22]
										wr_res = 1'b1;
										s_nxt.zero = (res == 8'h00);
									end
									mies_pkg::OP_MOVE_FILE_TO_ACC: begin
										s_nxt.acc = fv; // [RL5]
									end
									mies_pkg::OP_MOVE_LITERAL: begin
										s_nxt.acc = kv; // [RL6]
									end
									mies_pkg::OP_MOVE_ACC_TO_FILE: begin
										s_nxt.file[fa] = s_r.acc; // [RL7]
									end
									mies_pkg::OP_MOVE_ACC_TO_LOW_REG: begin
										s_nxt.file[{1'b0, iw[5:0]}] = s_r.acc; // [RL8]
									end
									mies_pkg::OP_ROTATE_LEFT: begin
										res = {fv[6:0], s_r.carry}; // [RL12]
										wr_res = 1'b1;
										s_nxt.carry = fv[7];
									end
									mies_pkg::OP_ROTATE_RIGHT: begin
										res = {s_r.carry, fv[7:1]}; // [RL13]
										wr_res = 1'b1;
										s_nxt.carry = fv[0];
									end
									mies_pkg::OP_NIBBLE_EXCHANGE: begin
										res = {fv[3:0], fv[7:4]}; // [RL17]
										wr_res = 1'b1;
									end
									mies_pkg::OP_ZERO_TEST: begin
										s_nxt.zero = (fv == 8'h00); // [RL20]
									end
									mies_pkg::OP_LITERAL_MINUS_ACC,
									mies_pkg::OP_FILE_MINUS_ACC: begin
										if (op == mies_pkg::OP_LITERAL_MINUS_ACC) begin
											fv = kv; // [RL15]
										end
										diff = {1'b0, fv} - {1'b0, s_r.acc}; // [RL16]
										hdiff = {1'b0, fv[3:0]} - {1'b0, s_r.acc[3:0]};
										res = diff[7:0];
										s_nxt.carry = ~diff[8];
										s_nxt.half_rollover_bit = ~hdiff[4];
										s_nxt.zero = (diff[7:0] == 8'h00);
										if (op == mies_pkg::OP_LITERAL_MINUS_ACC) begin
											s_nxt.acc = diff[7:0];
										end else begin
											wr_res = 1'b1;
										end
									end
									mies_pkg::OP_POWER_DOWN: begin
										s_nxt.timeout_flag = 1'b1; // [RL14]
										s_nxt.powerdown_flag = 1'b0;
										s_nxt.sleeping = 1'b1;
									end
									mies_pkg::OP_SUBROUTINE_RETURN,
									mies_pkg::OP_INTERRUPT_RETURN,
									mies_pkg::OP_LITERAL_RETURN: begin
										s_nxt.program_counter = s_r.stack[0]; // [RL9]
										for (int i = 0; i < STACK_DEPTH - 1; i++) begin
											s_nxt.stack[i] = s_r.stack[i + 1];
										end
										s_nxt.stack[STACK_DEPTH-1] = '0;
										if (s_r.depth != '0) begin
											s_nxt.depth = SP_W'(s_r.depth - 1'b1);
										end
										if (op == mies_pkg::OP_INTERRUPT_RETURN) begin
											s_nxt.global_irq_enable = 1'b1; // [RL10]
										end
										if (op == mies_pkg::OP_LITERAL_RETURN) begin
											s_nxt.acc = kv; // [RL11]
										end
										s_nxt.waitreq = 1'b1;
										s_nxt.st = mies_pkg::ST_EXEC2;
									end
									mies_pkg::OP_TABLE_READ_UPPER,
									mies_pkg::OP_TABLE_READ_LOWER: begin
										s_nxt.rom_addr = ROM_AW'({
											s_r.file[mies_pkg::FADDR_TABLE_HIGH],
											s_r.file[mies_pkg::FADDR_INDIRECT_SELECT]}); // [RL18]
										s_nxt.rom_rd = 1'b1;
										s_nxt.tbl_upper = (op == mies_pkg::OP_TABLE_READ_UPPER);
										s_nxt.waitreq = 1'b1;
										s_nxt.st = mies_pkg::ST_EXEC2;
									end
									default: begin
									end
								endcase
								if (wr_res) begin
									if (dst_file) begin
										s_nxt.file[fa] = res;
									end else begin
										s_nxt.acc = res;
									end
								end
							end
							mies_pkg::REG_ACC: begin
								wv = merge16({8'h00, s_r.acc}, avs_writedata_i,
									avs_byteenable_i);
								s_nxt.acc = wv[7:0];
							end
							mies_pkg::REG_STATUS: begin
								if (avs_byteenable_i[0]) begin
									s_nxt.carry = avs_writedata_i[mies_pkg::ST_CARRY];
									s_nxt.half_rollover_bit =
										avs_writedata_i[mies_pkg::ST_HALF_ROLLOVER];
									s_nxt.zero = avs_writedata_i[mies_pkg::ST_ZERO];
									s_nxt.global_irq_enable =
										avs_writedata_i[mies_pkg::ST_GLOBAL_IRQ];
									// writing one here wakes the core
									if (avs_writedata_i[mies_pkg::ST_SLEEPING]) begin
										s_nxt.sleeping = 1'b0;
									end
								end
							end
							mies_pkg::REG_PROG_COUNT: begin
								wv = merge16(16'(s_r.program_counter),
									avs_writedata_i, avs_byteenable_i);
								s_nxt.program_counter = wv[ROM_AW-1:0];
							end
							mies_pkg::REG_FILE_INDEX: begin
								if (avs_byteenable_i[0]) begin
									s_nxt.file_index = avs_writedata_i[6:0];
								end
							end
							mies_pkg::REG_FILE_DATA: begin
								if (avs_byteenable_i[0]) begin
									s_nxt.file[s_r.file_index] = avs_writedata_i[7:0];
								end
							end
							mies_pkg::REG_STACK: begin
								// push a return address; oldest entry falls off
								wv = merge16(16'h0000, avs_writedata_i,
									avs_byteenable_i);
								for (int i = STACK_DEPTH - 1; i > 0; i--) begin
									s_nxt.stack[i] = s_r.stack[i - 1];
								end
								s_nxt.stack[0] = wv[ROM_AW-1:0];
								if (s_r.depth != SP_W'(STACK_DEPTH)) begin
									s_nxt.depth = SP_W'(s_r.depth + 1'b1);
								end
							end
							default: begin
							end
						endcase
					end else if (avs_read_i) begin
						s_nxt.waitreq = 1'b0;
						s_nxt.st = mies_pkg::ST_ACK;
						s_nxt.rdata = '0;
						unique case (avs_address_i)
							mies_pkg::REG_INSTR: s_nxt.rdata = 32'(s_r.last_instr);
							mies_pkg::REG_ACC: s_nxt.rdata = 32'(s_r.acc);
							mies_pkg::REG_STATUS: begin
								s_nxt.rdata[mies_pkg::ST_CARRY] = s_r.carry;
								s_nxt.rdata[mies_pkg::ST_HALF_ROLLOVER] =
									s_r.half_rollover_bit;
								s_nxt.rdata[mies_pkg::ST_ZERO] = s_r.zero;
								s_nxt.rdata[mies_pkg::ST_POWERDOWN_FLAG] =
									s_r.powerdown_flag;
								s_nxt.rdata[mies_pkg::ST_TIMEOUT_FLAG] = s_r.timeout_flag;
								s_nxt.rdata[mies_pkg::ST_GLOBAL_IRQ] =
									s_r.global_irq_enable;
								s_nxt.rdata[mies_pkg::ST_SLEEPING] = s_r.sleeping;
								s_nxt.rdata[mies_pkg::ST_SKIP_PENDING] = s_r.skip;
							end
							mies_pkg::REG_PROG_COUNT: begin
								s_nxt.rdata = 32'(s_r.program_counter);
							end
							mies_pkg::REG_FILE_INDEX: s_nxt.rdata = 32'(s_r.file_index);
							mies_pkg::REG_FILE_DATA: begin
								s_nxt.rdata = 32'(s_r.file[s_r.file_index]);
							end
							mies_pkg::REG_STACK: begin
								s_nxt.rdata[15:0] = 16'(s_r.stack[0]);
								s_nxt.rdata[23:16] = 8'(s_r.depth);
							end
							default: s_nxt.rdata = '0;
						endcase
					end
				end
				mies_pkg::ST_EXEC2: begin
					// second cycle: rom word taken, or return flush
					if (s_r.rom_rd) begin
						s_nxt.acc = s_r.tbl_upper
							? {2'b00, rom_data_i[13:8]} // [RL18]
							: rom_data_i[7:0]; // [RL19]
						s_nxt.rom_rd = 1'b0;
					end
					s_nxt.waitreq = 1'b0;
					s_nxt.st = mies_pkg::ST_ACK;
				end
				mies_pkg::ST_ACK: begin
					s_nxt.waitreq = 1'b1;
					s_nxt.st = mies_pkg::ST_IDLE;
				end
				default: begin
					s_nxt.waitreq = 1'b1;
					s_nxt.st = mies_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		s_r <= s_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avs_readdata_o = s_r.rdata;
	assign avs_waitrequest_o = s_r.waitreq;
	assign rom_addr_o = s_r.rom_addr;
	assign rom_rd_o = s_r.rom_rd;
	assign osc_stop_o = s_r.sleeping;
	assign global_irq_enable_o = s_r.global_irq_enable;

endmodule

`default_nettype wire

// ---- test/mies_core_assertions.sv ----
// mies_core_assertions: port-level timing checks of the execute block.
// assumes: bound into mies_core, one clock, synchronous low reset.
`timescale 1ns/1ns
`default_nettype none
module mies_core_assertions #(parameter int ROM_AW = 11) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic [mies_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic avs_waitrequest_o,
	input wire logic [ROM_AW-1:0] rom_addr_o,
	input wire logic rom_rd_o,
	input wire logic osc_stop_o,
	input wire logic global_irq_enable_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic [13:0] iw = avs_writedata_i[13:0];
	// ----------------------------------------------------------------
	// instruction taken while awake
	// ----------------------------------------------------------------
	sequence s_take;
		$rose(avs_write_i) && avs_address_i == 6'h00 && clk_en_i && !osc_stop_o;
	endsequence
	sequence s_slow_ack;
		avs_waitrequest_o ##1 !avs_waitrequest_o;
	endsequence
	AST_LIT_ONE_CYCLE:
	assert property (s_take ##0 iw[13:8] inside {6'h19, 6'h1A, 6'h1D, 6'h1F}
		|=> !avs_waitrequest_o) else $error("literal op ack late");
	AST_RET_TWO_CYCLE:
	assert property (s_take ##0 (iw == 14'h0040 || iw == 14'h0060
		|| iw[13:8] == 6'h18) |=> s_slow_ack) else $error("return not two cycles");
	AST_TAB_TWO_CYCLE:
	assert property (s_take ##0 (iw == 14'h0050 || iw == 14'h0058)
		|=> rom_rd_o ##0 s_slow_ack) else $error("table read timing wrong");
	AST_ROM_PULSE:
	assert property (rom_rd_o |=> !rom_rd_o) else $error("rom read too long");
	AST_ROM_ADDR_HOLD:
	assert property ($past(rst_n_i) && !rom_rd_o |-> $stable(rom_addr_o))
		else $error("rom address moved outside a read");
	AST_SLEEP_ENTRY:
	assert property (s_take ##0 iw == 14'h0003 |=> osc_stop_o && !avs_waitrequest_o)
		else $error("power-down not entered in one cycle");
	AST_SLEEP_HOLD:
	assert property (osc_stop_o && !avs_write_i |=> osc_stop_o)
		else $error("oscillator restarted without a write");
	AST_IRQ_ON_RETURN:
	assert property (s_take ##0 iw == 14'h0060 |-> ##[1:2] global_irq_enable_o)
		else $error("interrupt return left enable low");
endmodule
bind mies_core mies_core_assertions #(.ROM_AW(ROM_AW)) chk_u (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
	.avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
	.rom_addr_o(rom_addr_o), .rom_rd_o(rom_rd_o), .osc_stop_o(osc_stop_o),
	.global_irq_enable_o(global_irq_enable_o));
`default_nettype wire

// ---- test/mies_core_bench.sv ----
// mies_core_bench: random and directed checks of the execute block.
// assumes: rom model beside the design, avalon master driven here.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end
module mies_core_bench;
	localparam int AW = 11;
	logic sys_clk_i = 0, rst_n_i = 0, clk_en_i = 1, rd = 0, wr = 0;
	logic wait_o, osc, irq, rrd;
	logic [5:0] adr = 0;
	logic [31:0] wdat = 0, rdat, q, t, seed = 32'hC9B7;
	logic [AW-1:0] radr, prog_m = 0;
	logic [13:0] rdw, w;
	logic [7:0] fm [128] = '{default: 8'h00};
	logic [7:0] acc_m = 0;
	logic c_m = 0, hr_m = 0, z_m = 0, pwr_m = 1, to_m = 1, irq_m = 0;
	logic sl_m = 0, sk_m = 0;
	int num_errors = 0, compares = 0, cyc = 0;
	mies_core #(.ROM_AW(AW)) dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .rom_addr_o(radr),
		.rom_rd_o(rrd), .rom_data_i(rdw), .osc_stop_o(osc),
		.global_irq_enable_o(irq));
	mies_rom_model #(.AW(AW)) rom_u (.sys_clk_i(sys_clk_i), .rom_rd_i(rrd),
		.rom_addr_i(radr), .rom_data_o(rdw));
	always #20 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			final_report();
		end
	end
	// ----------------------------------------------------------------
	// stimulus, reference model and bus master
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [13:0] pick(input logic [31:0] r);
		logic [5:0] ops [14] = '{6'h02, 6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C,
			6'h0D, 6'h0E, 6'h0F, 6'h19, 6'h1A, 6'h1D, 6'h1F, 6'h00};
		logic [5:0] op;
		op = ops[r[31:16] % 14];
		if (op[4]) return {op, r[7:0]};
		if (op == 6'h00) return r[9] ? {7'h01, 4'h4, r[2:0]} : {11'h004, r[2:0]};
		return {op, r[8], 4'h4, r[2:0]};
	endfunction
	function automatic void model(input logic [13:0] iw);
		logic [7:0] f, s, r;
		f = fm[iw[6:0]];
		s = iw[12] ? iw[7:0] : f;
		r = acc_m;
		if (sl_m) return;
		prog_m++;
		if (sk_m) begin
			sk_m = 0;
			return;
		end
		case (iw[13:8])
		6'h00: begin
			if (iw[7]) fm[iw[6:0]] = acc_m;
			else if (iw[7:6] == 0 && !(iw[5:0] inside {0, 3, 4})) fm[iw[5:0]] = acc_m;
			if (iw == 14'h0003) begin
				sl_m = 1;
				pwr_m = 0;
			end
			return;
		end
		6'h02, 6'h1D: begin
			r = s - acc_m;
			c_m = s >= acc_m;
			hr_m = s[3:0] >= acc_m[3:0];
		end
		6'h04, 6'h1A: r = acc_m | s;
		6'h06, 6'h1F: r = acc_m ^ s;
		6'h08: begin
			z_m = iw[7] ? f == 0 : z_m;
			if (iw[7]) return;
			r = f;
		end
		6'h0A, 6'h0F: r = f + 1;
		6'h0C: {r, c_m} = {c_m, f};
		6'h0D: {c_m, r} = {f, c_m};
		6'h0E: r = {f[3:0], f[7:4]};
		6'h19: r = s;
		default: return;
		endcase
		if (iw[13:8] == 6'h0F) sk_m = r == 0;
		if (iw[13:8] inside {6'h02, 6'h04, 6'h06, 6'h0A, 6'h1A, 6'h1D, 6'h1F}) z_m = r == 0;
		if (iw[7] && !iw[12]) fm[iw[6:0]] = r;
		else acc_m = r;
	endfunction
	function automatic logic [13:0] rom_w(input logic [AW-1:0] a);
		return {a[AW-1:AW-6] ^ 6'h2A, a[7:0] ^ 8'h5C};
	endfunction
	task automatic bus(input logic wn, input logic [5:0] a, input logic [31:0] d);
		logic [31:0] r;
		r = rnd();
		@(posedge sys_clk_i);
		clk_en_i <= |r[1:0];
		@(posedge sys_clk_i);
		clk_en_i <= 1;
		wr <= wn;
		rd <= !wn;
		adr <= a;
		wdat <= d;
		do @(posedge sys_clk_i); while (wait_o !== 1'b0);
		q = rdat;
		wr <= 0;
		rd <= 0;
	endtask
	task automatic ex(input logic [13:0] iw);
		bus(1, 6'h00, {18'h0, iw});
		model(iw);
	endtask
	task automatic setf(input logic [6:0] a, input logic [7:0] v);
		bus(1, 6'h10, {25'h0, a});
		bus(1, 6'h14, {24'h0, v});
		fm[a] = v;
	endtask
	task automatic chk_state();
		bus(0, 6'h04, 0);
		`CHK(q, {24'h0, acc_m})
		bus(0, 6'h08, 0);
		`CHK(q, {24'h0, sk_m, sl_m, irq_m, to_m, pwr_m, z_m, hr_m, c_m})
		bus(0, 6'h0C, 0);
		`CHK(q, 32'(prog_m))
	endtask
	task automatic final_report();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge sys_clk_i);
		rst_n_i <= 1;
		chk_state();
		for (int i = 0; i < 8; i++) setf(7'(32 + i), 8'(rnd()));
		setf(7'h21, 8'hFF);
		ex(14'h0AA1);
		setf(7'h22, 8'hFF);
		ex(14'h0F22);
		ex(14'h195A);
		chk_state();
		ex(14'h1910);
		ex(14'h1D05);
		chk_state();
		repeat (80) begin
			t = rnd();
			ex(pick(t));
			chk_state();
		end
		ex(14'h0000);
		bus(1, 6'h18, 32'h0123);
		bus(1, 6'h18, 32'h0456);
		ex(14'h0040);
		prog_m = 11'h456;
		chk_state();
		ex(14'h1877);
		{prog_m, acc_m} = {11'h123, 8'h77};
		chk_state();
		ex(14'h0060);
		{prog_m, irq_m} = 12'h001;
		`CHK(irq, irq_m)
		chk_state();
		t = rnd();
		setf(7'h04, t[7:0]);
		setf(7'h05, t[15:8]);
		w = rom_w(AW'({fm[5], fm[4]}));
		ex(14'h0050);
		acc_m = w[7:0];
		chk_state();
		ex(14'h0058);
		acc_m = {2'b00, w[13:8]};
		chk_state();
		`CHK(radr, AW'({fm[5], fm[4]}))
		ex(14'h0003);
		ex(14'h19AA);
		bus(0, 6'h00, 0);
		`CHK(q, 32'h19AA)
		chk_state();
		`CHK(osc, 1'b1)
		bus(1, 6'h08, 32'h40);
		{sl_m, irq_m, z_m, hr_m, c_m} = 5'h00;
		chk_state();
		`CHK(osc, 1'b0)
		bus(1, 6'h1C, 32'hFF);
		bus(0, 6'h1C, 0);
		`CHK(q, 32'h0)
		for (int i = 0; i < 8; i++) begin
			bus(1, 6'h10, 32 + i);
			bus(0, 6'h14, 0);
			`CHK(q, {24'h0, fm[32 + i]})
		end
		final_report();
	end
endmodule
`default_nettype wire

// ---- test/mies_rom_model.sv ----
// mies_rom_model: combinational program rom with a fixed word pattern.
// assumes: read strobe one cycle, data sampled at the edge ending it.
`timescale 1ns/1ns
`default_nettype none
module mies_rom_model #(parameter int AW = 11) (
	input wire logic sys_clk_i,
	input wire logic rom_rd_i,
	input wire logic [AW-1:0] rom_addr_i,
	output logic [13:0] rom_data_o
);
	logic [13:0] last_r = 14'h1555;
	// outside a read the bus shows the inverse of the last word
	always_comb rom_data_o = rom_rd_i ? {rom_addr_i[AW-1:AW-6] ^ 6'h2A,
		rom_addr_i[7:0] ^ 8'h5C} : ~last_r;
	always_ff @(posedge sys_clk_i) if (rom_rd_i) last_r <= rom_data_o;
endmodule
`default_nettype wire
